// ==== inc/pbs_pkg.sv ====
/*
  Shared constants and carrier types for the pipelined burst SRAM cycle control.
  Assumes a single 40 MHz clock domain and synchronous active-low reset.
*/
package pbs_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int PBS_ADDR_W = 18;
  localparam int PBS_DATA_W = 32;
  localparam int PBS_LANES = 4;
  localparam int PBS_LANE_W = 8;
  localparam int PBS_DEPTH = 262144;
  // Burst counter occupies the low address bits
  localparam int PBS_BURST_LSB = 0;
  localparam int PBS_BURST_W = 2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int PBS_CLK_PERIOD_NS = 25;
  localparam int PBS_SLEEP_ENTRY_CYC = 2;
  localparam int PBS_SLEEP_ENTRY_NS = PBS_SLEEP_ENTRY_CYC * PBS_CLK_PERIOD_NS;
  localparam int PBS_SLEEP_CNT = (PBS_SLEEP_ENTRY_NS / PBS_CLK_PERIOD_NS < 1) ? 1 :
                                  PBS_SLEEP_ENTRY_NS / PBS_CLK_PERIOD_NS;
  // ----------------------------------------
  // Reset values and types
  // ----------------------------------------
  localparam logic [1:0] PBS_CNT_RST = 2'h0;
  localparam logic [17:0] PBS_ADDR_RST = 18'h00000;

  typedef enum logic [1:0] {PBS_IDLE, PBS_READ, PBS_WRITE} pbs_cyc_e;

  // Synchronous control pins sampled at each edge
  typedef struct packed {
    logic chip_select_1_n;
    logic chip_select_2;
    logic chip_select_3_n;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_advance_n;
    logic global_write_n;
    logic byte_write_gate_n;
    logic [3:0] lane_write_select_n;
  } pbs_ctrl_s;

  // Next burst address within the four-beat wrap
  function automatic logic [1:0] pbs_next_beat(input logic [1:0] cur, input logic [1:0] start,
                                               input logic linear);
    logic [1:0] step;
    step = (cur ^ start) + 2'h1;
    return linear ? cur + 2'h1 : start ^ step;
  endfunction : pbs_next_beat
endpackage : pbs_pkg

// ==== verilog/pbs_mem.sv ====
/*
  Byte-lane writable storage array with registered read data.
  Assumes write and read addresses are settled at the clock edge.
*/
module pbs_mem import pbs_pkg::*; (
  // Clock
  input wire logic sys_clk,
  // Access
  input wire logic [PBS_ADDR_W-1:0] addr,
  input wire logic [PBS_LANES-1:0] lane_we,
  input wire logic [PBS_DATA_W-1:0] wdata,
  output logic [PBS_DATA_W-1:0] rdata
);
  // ----------------------------------------
  // Array
  // ----------------------------------------
  logic [PBS_DATA_W-1:0] mem [PBS_DEPTH]; // Contents kept through sleep

  // Lane writes and registered read
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < PBS_LANES; i++) begin
      if (lane_we[i]) begin
        mem[addr][i*PBS_LANE_W +: PBS_LANE_W] <= wdata[i*PBS_LANE_W +: PBS_LANE_W];
      end
    end
    rdata <= mem[addr];
  end
endmodule : pbs_mem

// ==== verilog/pbs_sleep.sv ====
/*
  Sleep entry sequencer: counts the entry interval after sleep_request rises.
  Assumes sleep_request is already synchronous to sys_clk.
*/
module pbs_sleep import pbs_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic sleep_request,
  output logic asleep
);
  // ----------------------------------------
  // Entry counter
  // ----------------------------------------
  logic [1:0] cnt; // Cycles since request
  logic [1:0] next_cnt;
  wire logic reached = (cnt == 2'(PBS_SLEEP_CNT - 1));

  assign next_cnt = !sleep_request ? PBS_CNT_RST : (reached ? cnt : cnt + 2'h1);

  // Count while request held, asleep once interval done
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt <= PBS_CNT_RST;
      asleep <= 1'b0;
    end else begin
      cnt <= next_cnt;
      // Flag one edge early: the top's output flop adds the second cycle
      asleep <= sleep_request && (next_cnt == 2'(PBS_SLEEP_CNT - 1));
    end
  end

  // Sleep reached within two cycles of a held request
  property p_sleep_entry;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(sleep_request) ##0 sleep_request[*2] |-> asleep;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry too slow");
endmodule : pbs_sleep

// ==== verilog/pbs_ctrl.sv ====
/*
  Pipelined burst SRAM cycle control: decodes strobes, chip selects and write
  controls at each edge into begin, continue or suspend of a burst, runs the
  two-bit burst counter, byte-lane writes, output drive and sleep.
  Assumes a requester on the same clock; data pin is split into in/out/enable.
*/
//
// How it works
// - Write when global or gated lane select
// - Byte gate writes only selected lanes
// - Global write writes all four lanes
// - Processor strobe start is always a read
// - Writes only after processor start or controller
// - Output enable asynchronous (sampled each edge here), masked during writes
// - Read drives when enabled, floats otherwise
// - Advance low continues to next address
// - Advance high suspends at current address
// - Continue/suspend writes take data in
// - Controller strobe read starts external burst
// - Sleep entered within two clock cycles
// - Two-bit counter, interleaved or linear order
// - Deselect floats outputs one cycle later
module pbs_ctrl import pbs_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Synchronous controls
  input wire pbs_ctrl_s ctrl,
  input wire logic linear_order,
  input wire logic [PBS_ADDR_W-1:0] addr,
  // Asynchronous controls
  input wire logic output_drive_enable_n,
  input wire logic sleep_request,
  // Data pins
  input wire logic [PBS_DATA_W-1:0] dq_in,
  output logic [PBS_DATA_W-1:0] dq_out,
  output logic dq_oe,
  // Status
  output logic asleep
);
  // ----------------------------------------
  // Cycle decode
  // ----------------------------------------
  logic [PBS_ADDR_W-1:0] base_addr; // Captured external address
  logic [1:0] beat; // Burst counter
  logic [1:0] start_beat; // First beat of burst
  logic burst_mode; // Order captured at burst start
  pbs_cyc_e cyc; // Cycle registered last edge
  logic drive_hold; // Extra deselect cycle
  logic [PBS_DATA_W-1:0] rdata; // Array read register
  logic sleep_now; // Sleep from sequencer

  // Chip select active only when all three agree
  wire logic selected = !ctrl.chip_select_1_n && ctrl.chip_select_2 && !ctrl.chip_select_3_n;
  // Processor strobe is ignored while chip_select_1 is high
  wire logic psn_start = !ctrl.processor_addr_strobe_n && !ctrl.chip_select_1_n;
  // Controller start proper needs the processor strobe high
  wire logic csn_start = !ctrl.controller_addr_strobe_n && ctrl.processor_addr_strobe_n;
  // Either strobe opens a cycle; the selects then pick begin or deselect
  wire logic strobe = psn_start || !ctrl.controller_addr_strobe_n;
  wire logic begin_burst = strobe && selected;
  wire logic deselect = strobe && !selected;
  // No strobe: continue or suspend the running burst
  wire logic hold_burst = !strobe && (cyc != PBS_IDLE || drive_hold);
  wire logic advance = hold_burst && !ctrl.burst_advance_n;

  // Write decode
  wire logic any_lane = ~&ctrl.lane_write_select_n;
  wire logic wr_req = !ctrl.global_write_n || (!ctrl.byte_write_gate_n && any_lane);
  // Processor-strobe start forces a read; writes only on controller start or later
  wire logic is_write = wr_req && !psn_start && (csn_start || hold_burst);
  // Global write overrides lane selects
  wire logic [3:0] lane_mask = !ctrl.global_write_n ? 4'hF : ~ctrl.lane_write_select_n;

  // Ignore synchronous inputs while asleep
  wire logic active = !sleep_request;

  // Burst address generation
  wire logic [1:0] next_beat = begin_burst ? addr[1:0] :
                               advance ? pbs_next_beat(beat, start_beat, burst_mode) : beat;
  // A suspend re-uses the current beat, a continue the stepped one
  wire logic [PBS_ADDR_W-1:0] access_addr = begin_burst ? addr :
                                            {base_addr[PBS_ADDR_W-1:2], next_beat};
  // Storage is written only in a decoded write cycle, never while asleep
  wire logic do_write = active && is_write && (begin_burst || hold_burst);
  wire logic [3:0] lane_we = do_write ? lane_mask : 4'h0;

  // Next cycle kind
  wire pbs_cyc_e next_cyc = !active ? PBS_IDLE :
                            deselect ? PBS_IDLE :
                            (begin_burst || hold_burst) ? (is_write ? PBS_WRITE : PBS_READ) : PBS_IDLE;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  pbs_mem u_mem (
    .sys_clk(sys_clk),
    .addr(access_addr),
    .lane_we(lane_we),
    .wdata(dq_in),
    .rdata(rdata)
  );

  pbs_sleep u_sleep (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sleep_request(sleep_request),
    .asleep(sleep_now)
  );

  // ----------------------------------------
  // Burst state
  // ----------------------------------------
  // Capture address and order at burst start, step counter on advance
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      base_addr <= PBS_ADDR_RST;
      beat <= PBS_CNT_RST;
      start_beat <= PBS_CNT_RST;
      burst_mode <= 1'b0;
    end else if (active && begin_burst) begin
      base_addr <= addr;
      beat <= addr[1:0];
      start_beat <= addr[1:0];
      burst_mode <= linear_order;
    end else if (active) begin
      beat <= next_beat;
    end
  end

  // Cycle kind register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cyc <= PBS_IDLE;
    end else begin
      cyc <= next_cyc;
    end
  end

  // ----------------------------------------
  // Output pipeline
  // ----------------------------------------
  // Read data appears one edge after the address; a deselect keeps driving one more cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drive_hold <= 1'b0;
      dq_out <= '0;
    end else begin
      drive_hold <= active && cyc == PBS_READ && deselect;
      dq_out <= rdata;
    end
  end

  // Enable flop: the enable pin acts unclocked in silicon; here it is sampled
  // each edge because every output must come from a flip-flop
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dq_oe <= 1'b0;
      asleep <= 1'b0;
    end else begin
      // Masked during writes, floats while asleep
      // Drive only once read data sits in the output register, so the first
      // cycle of an access floats and a deselect still drives one more cycle
      dq_oe <= cyc == PBS_READ && !is_write && !output_drive_enable_n &&
               active && !sleep_now;
      asleep <= sleep_now;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_no_drive_write;
    @(posedge sys_clk) disable iff (!rst_n)
      (cyc == PBS_WRITE) |-> !dq_oe || $past(cyc) == PBS_READ;
  endproperty
  a_no_drive_write: assert property (p_no_drive_write) else $error("driving during write");

  property p_oe_high_floats;
    @(posedge sys_clk) disable iff (!rst_n)
      output_drive_enable_n |=> !dq_oe;
  endproperty
  a_oe_high_floats: assert property (p_oe_high_floats) else $error("drive with enable high");

  property p_psn_read;
    @(posedge sys_clk) disable iff (!rst_n)
      (active && psn_start && selected) |=> cyc == PBS_READ;
  endproperty
  a_psn_read: assert property (p_psn_read) else $error("processor start not read");

  property p_psn_no_write;
    @(posedge sys_clk) disable iff (!rst_n)
      psn_start |-> lane_we == 4'h0;
  endproperty
  a_psn_no_write: assert property (p_psn_no_write) else $error("write on processor start");

  property p_global_all;
    @(posedge sys_clk) disable iff (!rst_n)
      (do_write && !ctrl.global_write_n) |-> lane_we == 4'hF;
  endproperty
  a_global_all: assert property (p_global_all) else $error("global write missed lanes");

  property p_lane_sel;
    @(posedge sys_clk) disable iff (!rst_n)
      (do_write && ctrl.global_write_n) |-> lane_we == ~ctrl.lane_write_select_n;
  endproperty
  a_lane_sel: assert property (p_lane_sel) else $error("wrong byte lanes");

  property p_read_decode;
    @(posedge sys_clk) disable iff (!rst_n)
      (ctrl.global_write_n && (ctrl.byte_write_gate_n || !any_lane)) |-> lane_we == 4'h0;
  endproperty
  a_read_decode: assert property (p_read_decode) else $error("read decoded as write");

  property p_suspend;
    @(posedge sys_clk) disable iff (!rst_n)
      (active && hold_burst && ctrl.burst_advance_n) |=> beat == $past(beat);
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend moved counter");

  property p_continue;
    @(posedge sys_clk) disable iff (!rst_n)
      (active && advance && burst_mode) |=> beat == $past(beat) + 2'h1;
  endproperty
  a_continue: assert property (p_continue) else $error("linear advance wrong");

  property p_sleep_float;
    @(posedge sys_clk) disable iff (!rst_n)
      sleep_request |=> !dq_oe;
  endproperty
  a_sleep_float: assert property (p_sleep_float) else $error("driving in sleep");

  // A write edge leaves the pins floating for the next cycle
  property p_write_mask;
    @(posedge sys_clk) disable iff (!rst_n)
      is_write |=> !dq_oe;
  endproperty
  a_write_mask: assert property (p_write_mask) else $error("drive after write edge");

  // Nothing read at the last edge means nothing to drive yet
  property p_idle_floats;
    @(posedge sys_clk) disable iff (!rst_n)
      (cyc == PBS_IDLE) |=> !dq_oe;
  endproperty
  a_idle_floats: assert property (p_idle_floats) else $error("drive in first cycle");

  // Last read data still driven in the cycle after a deselect
  property p_deselect_drive;
    @(posedge sys_clk) disable iff (!rst_n)
      (active && deselect && cyc == PBS_READ && !wr_req && !output_drive_enable_n && !sleep_now) |=> dq_oe;
  endproperty
  a_deselect_drive: assert property (p_deselect_drive) else $error("deselect dropped drive early");

  // Pins released one edge after that
  property p_deselect_float;
    @(posedge sys_clk) disable iff (!rst_n)
      (active && deselect) |=> ##1 !dq_oe;
  endproperty
  a_deselect_float: assert property (p_deselect_float) else $error("deselect drove too long");

  // Burst counter loads the low address bits at a start
  property p_burst_load;
    @(posedge sys_clk) disable iff (!rst_n)
      (active && begin_burst) |=> beat == $past(addr[1:0]);
  endproperty
  a_burst_load: assert property (p_burst_load) else $error("counter not loaded");

  // Interleaved order counts up in the bits that differ from the start
  property p_interleave;
    @(posedge sys_clk) disable iff (!rst_n)
      (active && advance && !burst_mode) |=> (beat ^ start_beat) == $past(beat ^ start_beat) + 2'h1;
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleaved advance wrong");

  // No storage write while asleep
  property p_sleep_no_write;
    @(posedge sys_clk) disable iff (!rst_n)
      !active |-> lane_we == 4'h0;
  endproperty
  a_sleep_no_write: assert property (p_sleep_no_write) else $error("write in sleep");

  // Controller start with write controls writes at once
  property p_ctrl_write;
    @(posedge sys_clk) disable iff (!rst_n)
      (active && begin_burst && csn_start && wr_req) |-> lane_we != 4'h0;
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("controller write lost");

  // Continue or suspend with write controls takes data in
  property p_hold_write;
    @(posedge sys_clk) disable iff (!rst_n)
      (active && hold_burst && wr_req) |-> lane_we != 4'h0;
  endproperty
  a_hold_write: assert property (p_hold_write) else $error("burst write lost");

  // Output flag up two edges after the request is first seen
  property p_sleep_timely;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(sleep_request) ##1 sleep_request |=> asleep;
  endproperty
  a_sleep_timely: assert property (p_sleep_timely) else $error("sleep flag late");
endmodule : pbs_ctrl

// ==== sim/pbs_req_model.sv ====
/*
  Requester model: processor or cache controller driving the burst SRAM bus.
  Assumes the bench calls one task per clock cycle and owns the sequence.
*/
module pbs_req_model import pbs_pkg::*; (
  // Clock
  input wire logic sys_clk,
  // Bus outputs
  output pbs_ctrl_s ctrl,
  output logic linear_order,
  output logic [PBS_ADDR_W-1:0] addr,
  output logic output_drive_enable_n,
  output logic sleep_request,
  output logic [PBS_DATA_W-1:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet bus: selects and strobes inactive
  localparam pbs_ctrl_s QUIET = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF};
  logic oe_sel; // Enable level wanted on reads
  logic order; // Burst order for the next start
  // Time-zero levels
  initial begin
    ctrl = QUIET;
    linear_order = 1'b0;
    addr = '0;
    output_drive_enable_n = 1'b1;
    sleep_request = 1'b0;
    dq_in = 32'h0F0F0F0F;
    oe_sel = 1'b0;
    order = 1'b0;
  end
  // ------------------------------
  // One bus cycle per call
  // ------------------------------
  task automatic cyc(input pbs_ctrl_s c, input logic [PBS_ADDR_W-1:0] a, input logic [PBS_DATA_W-1:0] d);
    logic wr;
    wr = !c.global_write_n || (!c.byte_write_gate_n && c.lane_write_select_n != 4'hF);
    @(posedge sys_clk);
    ctrl <= c;
    addr <= a;
    linear_order <= order;
    output_drive_enable_n <= wr | oe_sel; // Pins released whenever data is offered
    dq_in <= wr ? d : ~dq_in; // Unused data lines toggle, so stale data never matches
  endtask : cyc
  // Sleep entry or exit, bus kept quiet
  task automatic sleep_set(input logic on);
    @(posedge sys_clk);
    ctrl <= QUIET;
    sleep_request <= on;
    if (!on) begin
      repeat (2) @(posedge sys_clk); // Recovery interval, still quiet
    end
  endtask : sleep_set
endmodule : pbs_req_model

// ==== sim/testbench.sv ====
/*
  Self-checking bench for the burst SRAM cycle control.
  Assumes the requester model drives every design input but clock and reset.
*/
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module testbench import pbs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, linear_order, oe_n, sleep_request, dq_oe, asleep;
  pbs_ctrl_s ctrl;
  logic [PBS_ADDR_W-1:0] addr;
  logic [PBS_DATA_W-1:0] dq_in, dq_out;
  int fails = 0;
  int tests_run = 0;
  // Control word; select, strobes, advance and writes all active low
  function automatic pbs_ctrl_s mk(logic s, logic p, logic c, logic v, logic g, logic b, logic [3:0] l);
    return '{s, 1'b1, 1'b0, p, c, v, g, b, l};
  endfunction : mk
  localparam pbs_ctrl_s DS = mk(1, 1, 0, 1, 1, 1, 4'hF); // Deselect
  localparam pbs_ctrl_s PR = mk(0, 0, 1, 1, 1, 1, 4'hF); // Processor start
  localparam pbs_ctrl_s PW = mk(0, 0, 1, 1, 0, 1, 4'hF); // Processor start, write asked
  localparam pbs_ctrl_s CR = mk(0, 1, 0, 1, 1, 1, 4'hF); // Controller read
  localparam pbs_ctrl_s CW = mk(0, 1, 0, 1, 0, 1, 4'hF); // Controller global write
  localparam pbs_ctrl_s CO = mk(0, 1, 1, 0, 1, 1, 4'hF); // Continue read
  localparam pbs_ctrl_s SU = mk(0, 1, 1, 1, 1, 1, 4'hF); // Suspend read
  pbs_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .ctrl(ctrl), .linear_order(linear_order), .addr(addr),
    .output_drive_enable_n(oe_n), .sleep_request(sleep_request), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .asleep(asleep));
  pbs_req_model m (.sys_clk(sys_clk), .ctrl(ctrl), .linear_order(linear_order), .addr(addr),
    .output_drive_enable_n(oe_n), .sleep_request(sleep_request), .dq_in(dq_in));
  // ------------------------------
  // Scenarios
  // ------------------------------
  // Single read, data one edge after the address edge
  task automatic rd(input pbs_ctrl_s c, input logic [PBS_ADDR_W-1:0] a, input logic [PBS_DATA_W-1:0] e);
    m.cyc(c, a, '0);
    m.cyc(DS, a, '0);
    m.cyc(DS, a, '0);
    #1 `CHK(dq_out, e)
  endtask : rd
  // Byte lanes, then two refused writes
  task automatic t_lanes();
    m.cyc(CW, 18'h100, 32'hFFFFFFFF);
    m.cyc(mk(0, 1, 0, 1, 1, 0, 4'h5), 18'h100, 32'h0);
    m.cyc(mk(0, 1, 0, 1, 1, 1, 4'h0), 18'h100, 32'h0);
    m.cyc(mk(0, 1, 0, 1, 1, 0, 4'hF), 18'h100, 32'h0);
    rd(CR, 18'h100, 32'h00FF00FF);
  endtask : t_lanes
  // Processor start ignores writes; later edges may write
  task automatic t_late_write();
    m.cyc(CW, 18'h104, 32'h11111111);
    m.cyc(PW, 18'h104, 32'h0);
    m.cyc(mk(0, 1, 1, 0, 0, 1, 4'hF), 18'h104, 32'h22222222);
    m.cyc(DS, 18'h0, 32'h0);
    #1 `CHK(dq_oe, 1'b0)
    rd(PR, 18'h104, 32'h11111111);
    rd(PR, 18'h105, 32'h22222222);
    m.cyc(PW, 18'h108, 32'h0);
    m.cyc(mk(0, 1, 1, 1, 0, 1, 4'hF), 18'h108, 32'h33333333);
    rd(PR, 18'h108, 32'h33333333);
  endtask : t_late_write
  // Bursts in both orders with a suspended beat, then deselect
  task automatic t_burst();
    logic [1:0] idx;
    pbs_ctrl_s ops [6];
    ops = '{CO, SU, CO, DS, DS, DS};
    for (int i = 0; i < 4; i++) begin
      m.cyc(CW, 18'h200 + 18'(i), 32'hC0DE0000 + 32'(i));
    end
    for (int o = 0; o < 2; o++) begin
      m.order = o[0];
      m.cyc(PR, 18'h201, '0);
      for (int i = 0; i < 6; i++) begin
        m.cyc(ops[i], 18'h0, '0);
        #1;
        idx = o[0] ? 2'(1 + i / 2) : 2'(1 ^ (i / 2));
        if (i >= 1 && i <= 4) begin
          `CHK(dq_out, 32'hC0DE0000 + 32'(idx))
        end
        // First cycle of the access floats; drive holds one cycle past the deselect
        `CHK(dq_oe, i >= 1 && i < 5)
      end
    end
  endtask : t_burst
  // Enable high floats a read
  task automatic t_oe_high();
    m.oe_sel = 1'b1;
    m.cyc(PR, 18'h200, '0);
    m.cyc(CO, 18'h0, '0);
    m.cyc(CO, 18'h0, '0);
    #1 `CHK(dq_oe, 1'b0)
    m.oe_sel = 1'b0;
    m.cyc(DS, 18'h0, '0);
  endtask : t_oe_high
  // Sleep entry, ignored write, recovery keeps contents
  task automatic t_sleep();
    m.cyc(DS, 18'h0, '0);
    m.sleep_set(1'b1);
    repeat (2) @(posedge sys_clk);
    #1 `CHK(asleep, 1'b1)
    m.cyc(CW, 18'h104, 32'hDEADBEEF);
    m.cyc(DS, 18'h0, '0);
    #1 `CHK(dq_oe, 1'b0)
    m.sleep_set(1'b0);
    rd(PR, 18'h104, 32'h11111111);
  endtask : t_sleep
  // Counts and verdict
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // Clock, 25 ns period
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 `CHK({dq_oe, asleep, dq_out}, 34'h0)
    t_lanes();
    t_late_write();
    t_burst();
    t_oe_high();
    t_sleep();
    finish_test();
  end
endmodule : testbench
